//--- src/cisv_defs.svh
/*
 * Register offsets, field positions and reset values of the CAN
 * interrupt status and vector block.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
`ifndef CISV_DEFS_SVH
`define CISV_DEFS_SVH

// register byte offsets
`define CISV_OFS_FLAGS    12'h000
`define CISV_OFS_ENABLES  12'h004
`define CISV_OFS_CODE     12'h008

// event flag and enable positions
`define CISV_BIT_TXBUF    0
`define CISV_BIT_RXBUF    1
`define CISV_BIT_RXOVF    2
`define CISV_BIT_FIFO     3
`define CISV_BIT_ERR      5
`define CISV_BIT_WAKE     6
`define CISV_BIT_INVMSG   7

// fault-confinement status positions
`define CISV_BIT_ANYWARN  8
`define CISV_BIT_RXWARN   9
`define CISV_BIT_TXWARN   10
`define CISV_BIT_RXPASS   11
`define CISV_BIT_TXPASS   12
`define CISV_BIT_TXBOFF   13

// writable event bits of the low byte
`define CISV_EVENT_MASK   8'hEF

// code register fields
`define CISV_CODE_LSB     0
`define CISV_FILT_LSB     8

// source codes
`define CISV_CODE_NONE    7'h40
`define CISV_CODE_ERR     7'h41
`define CISV_CODE_WAKE    7'h42
`define CISV_CODE_RXOVF   7'h43
`define CISV_CODE_FIFO    7'h44

// reset values
`define CISV_RST_EVENTS   8'h00
`define CISV_RST_FILT     5'h00

`endif

//--- src/cisv_pkg.sv
/*
 * Types of the CAN interrupt status and vector block.
 * Assumes the constants header is compiled with it.
 */
`default_nettype none

package cisv_pkg;

	// fault-confinement levels from the protocol engine
	typedef struct packed {
		logic tx_bus_off;       // transmitter bus-off
		logic tx_error_passive; // transmitter error-passive
		logic rx_error_passive; // receiver error-passive
		logic tx_error_warning; // transmitter warning
		logic rx_error_warning; // receiver warning
	} cisv_fault_type;

	// one-cycle event strobes from the rest of the module
	typedef struct packed {
		logic       invalid_msg;   // invalid message seen
		logic       wakeup;        // bus wake-up activity
		logic       fifo_full;     // fifo almost full
		logic       rx_overflow;   // receive buffer overflow
		logic       rx_buffer;     // receive buffer event
		logic       tx_buffer;     // transmit buffer event
		logic [4:0] buffer_index;  // buffer of the buffer event
		logic [3:0] filter_hit;    // filter matched by the reception
	} cisv_event_type;

endpackage : cisv_pkg

`default_nettype wire

//--- src/cisv_top.sv
/*
 * CAN interrupt status and vector block: event flags, enables,
 * priority encoding of the pending source and the module request.
 * Assumes the fault inputs and strobes come from logic on pclk.
 */
`include "cisv_defs.svh"
`default_nettype none

// Overview of operation
// - bit 13 shows transmitter bus-off
// - bit 12 shows transmitter error-passive
// - bit 11 shows receiver error-passive
// - bit 10 shows transmitter error-warning
// - bit 9 shows receiver error-warning
// - bit 8 is either warning
// - error flag set by newly risen fault states
// - invalid-message bit 7, wake-up bit 6
// - fifo bit 3, overflow bit 2
// - rx bit 1, tx bit 0, others zero
// - flags cleared by writing zero only
// - per-source enables, reset zero
// - filter hit number in bits 12:8
// - codes for non-buffer sources but invalid-message
// - buffer events coded by index
// - reserved codes never output
// - code returns to none on clear
// - code uses enabled sources only
module cisv_top
	import cisv_pkg::*;
(
	// clock and reset
	input  wire logic           pclk,
	input  wire logic           presetn,
	// apb slave
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [11:0]    paddr,
	input  wire logic [31:0]    pwdata,
	input  wire logic [3:0]     pstrb,
	output logic                pready,
	output logic [31:0]         prdata,
	output logic                pslverr,
	// module side
	input  wire cisv_fault_type fault_in,
	input  wire cisv_event_type event_in,
	// request to the system interrupt controller
	output logic                module_irq
);

	logic [7:0]     events_ff;      // sticky event flags
	logic [7:0]     nxt_events;     // next flags
	logic [7:0]     enables_ff;     // per-source enables
	cisv_fault_type fault_ff;       // registered fault levels
	cisv_fault_type fault_prev_ff;  // previous fault levels
	logic [4:0]     filt_ff;        // last filter hit
	logic [4:0]     bufidx_ff;      // last buffer index
	logic [6:0]     code;           // encoded source
	logic [7:0]     pend;           // pending and enabled
	logic [15:0]    flags_view;     // flag register image
	logic [15:0]    code_view;      // code register image
	logic [31:0]    nxt_rdata;      // read mux
	logic           wr_acc;         // write access phase
	logic           rd_acc;         // read setup phase
	logic           known;          // mapped address
	logic           fault_rise;     // new fault condition

	// write access and read setup strobes; slave answers without wait states
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & ~penable & ~pwrite;
	assign known  = (paddr == `CISV_OFS_FLAGS) | (paddr == `CISV_OFS_ENABLES)
		| (paddr == `CISV_OFS_CODE);

	// fault levels are held for the error flag edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_ff      <= '0;
			fault_prev_ff <= '0;
		end else begin
			fault_ff      <= fault_in;
			fault_prev_ff <= fault_ff;
		end
	end

	// any fault level rising raises the error event
	assign fault_rise = |(fault_ff & ~fault_prev_ff);

	// sticky flags; a new event beats a simultaneous clear
	always_comb begin
		nxt_events = events_ff;
		if (wr_acc && (paddr == `CISV_OFS_FLAGS) && pstrb[0]) begin
			// zero clears, one keeps
			nxt_events = events_ff & pwdata[7:0];
		end
		// events set whatever the enables say
		if (event_in.tx_buffer)   nxt_events[`CISV_BIT_TXBUF]  = 1'b1;
		if (event_in.rx_buffer)   nxt_events[`CISV_BIT_RXBUF]  = 1'b1;
		if (event_in.rx_overflow) nxt_events[`CISV_BIT_RXOVF]  = 1'b1;
		if (event_in.fifo_full)   nxt_events[`CISV_BIT_FIFO]   = 1'b1;
		if (fault_rise)           nxt_events[`CISV_BIT_ERR]    = 1'b1;
		if (event_in.wakeup)      nxt_events[`CISV_BIT_WAKE]   = 1'b1;
		if (event_in.invalid_msg) nxt_events[`CISV_BIT_INVMSG] = 1'b1;
		nxt_events = nxt_events & `CISV_EVENT_MASK;
	end

	// flag storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) events_ff <= `CISV_RST_EVENTS;
		else          events_ff <= nxt_events;
	end

	// enable register, bit 4 unimplemented
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enables_ff <= `CISV_RST_EVENTS;
		end else if (wr_acc && (paddr == `CISV_OFS_ENABLES) && pstrb[0]) begin
			enables_ff <= pwdata[7:0] & `CISV_EVENT_MASK;
		end
	end

	// filter hit and buffer index of the latest buffer event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_ff   <= `CISV_RST_FILT;
			bufidx_ff <= 5'h00;
		end else if (event_in.rx_buffer || event_in.tx_buffer) begin
			// top bit stays zero so reserved numbers never appear
			filt_ff   <= {1'b0, event_in.filter_hit};
			bufidx_ff <= event_in.buffer_index;
		end
	end

	// pending sources gated by enables
	assign pend = events_ff & enables_ff;

	// fixed priority encoder; buffers rank last, none otherwise
	always_comb begin
		if (pend[`CISV_BIT_ERR])        code = `CISV_CODE_ERR;
		else if (pend[`CISV_BIT_WAKE])  code = `CISV_CODE_WAKE;
		else if (pend[`CISV_BIT_RXOVF]) code = `CISV_CODE_RXOVF;
		else if (pend[`CISV_BIT_FIFO])  code = `CISV_CODE_FIFO;
		else if (pend[`CISV_BIT_RXBUF] || pend[`CISV_BIT_TXBUF])
			code = {2'b00, bufidx_ff};
		else
			code = `CISV_CODE_NONE;
	end
	// invalid-message has no code of its own; it only requests

	// status half of the flag register comes from the registered levels
	always_comb begin
		flags_view = 16'h0000;
		flags_view[7:0]                = events_ff;
		flags_view[`CISV_BIT_TXBOFF]   = fault_ff.tx_bus_off;
		flags_view[`CISV_BIT_TXPASS]   = fault_ff.tx_error_passive;
		flags_view[`CISV_BIT_RXPASS]   = fault_ff.rx_error_passive;
		flags_view[`CISV_BIT_TXWARN]   = fault_ff.tx_error_warning;
		flags_view[`CISV_BIT_RXWARN]   = fault_ff.rx_error_warning;
		flags_view[`CISV_BIT_ANYWARN]  = fault_ff.tx_error_warning
			| fault_ff.rx_error_warning;
	end

	// code register image
	always_comb begin
		code_view = 16'h0000;
		code_view[`CISV_CODE_LSB +: 7] = code;
		code_view[`CISV_FILT_LSB +: 5] = filt_ff;
	end

	// read mux, unmapped reads as zero
	always_comb begin
		unique case (paddr)
			`CISV_OFS_FLAGS:   nxt_rdata = {16'h0000, flags_view};
			`CISV_OFS_ENABLES: nxt_rdata = {24'h000000, enables_ff};
			`CISV_OFS_CODE:    nxt_rdata = {16'h0000, code_view};
			default:           nxt_rdata = 32'h0000_0000;
		endcase
	end

	// read data captured in setup so it stands through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)    prdata <= 32'h0000_0000;
		else if (rd_acc) prdata <= nxt_rdata;
	end

	// ready registered in setup, high in the access cycle only: access phase takes one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pready <= 1'b0;
		else          pready <= psel & ~penable;
	end

	// error answer for unmapped addresses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pslverr <= 1'b0;
		else          pslverr <= psel & ~penable & ~known;
	end

	// module request; the system controller gates it further
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) module_irq <= 1'b0;
		else          module_irq <= |(nxt_events & enables_ff);
	end

endmodule : cisv_top

`default_nettype wire

//--- dv/cisv_asserts.sv
/* port-level checker of the interrupt status block.
   assumes the bind below attaches it to cisv_top. */
`default_nettype none
module cisv_asserts
	import cisv_pkg::*;
(
	// clock and reset
	input wire logic		pclk,
	input wire logic		presetn,
	// apb
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [11:0]	paddr,
	input wire logic [31:0]	prdata,
	input wire logic		pready,
	input wire logic		pslverr,
	// module side
	input wire cisv_fault_type	fault_in,
	input wire logic		module_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// read setups of the flag and code registers
	sequence s_flag_rd;
		psel && !penable && !pwrite && paddr == 12'h000;
	endsequence
	sequence s_code_rd;
		psel && !penable && !pwrite && paddr == 12'h008;
	endsequence
	property p_ready; psel && !penable |=> pready; endproperty
	property p_ready_once; pready |=> !pready; endproperty
	property p_slverr; psel && !penable && paddr > 12'h008 |=> pslverr; endproperty
	// status sampled one cycle late, captured at setup
	property p_status; s_flag_rd |=> prdata[13:9] == $past(fault_in, 2); endproperty
	property p_warn;
		s_flag_rd |=> prdata[8] == ($past(fault_in.tx_error_warning, 2)
			| $past(fault_in.rx_error_warning, 2));
	endproperty
	property p_zero; s_flag_rd |=> prdata[15:14] == 2'h0 && !prdata[4]; endproperty
	property p_code; s_code_rd |=> prdata[6:5] != 2'h1 && prdata[7:0] <= 8'h44; endproperty
	// request only drops after a write
	property p_irq_hold;
		module_irq && !$past(psel && penable && pwrite) && !(psel && penable && pwrite)
			|=> module_irq;
	endproperty
	a_ready: assert property (p_ready) else $error("ready missing");
	a_ready_once: assert property (p_ready_once) else $error("ready too long");
	a_slverr: assert property (p_slverr) else $error("no slave error");
	a_status: assert property (p_status) else $error("status bits wrong");
	a_warn: assert property (p_warn) else $error("combined warning wrong");
	a_zero: assert property (p_zero) else $error("unused bits set");
	a_code: assert property (p_code) else $error("reserved code");
	a_irq_hold: assert property (p_irq_hold) else $error("request dropped");
endmodule : cisv_asserts
bind cisv_top cisv_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .fault_in(fault_in), .module_irq(module_irq));
`default_nettype wire

//--- dv/cisv_sysirq.sv
/* system interrupt controller stand-in.
   assumes the bench drives its enable. */
`default_nettype none
module cisv_sysirq (
	// request, gate and result
	input wire logic	module_irq,
	input wire logic	sys_en,
	output logic		cpu_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// no processor interrupt unless gated on
	assign cpu_irq = module_irq & sys_en;
endmodule : cisv_sysirq
`default_nettype wire

//--- dv/cisv_top_tb.sv
/* self-checking bench of the interrupt status block.
   assumes cisv_top, its package and the stand-in are compiled. */
`default_nettype none
module cisv_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cisv_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, module_irq, cpu_irq, slv, sys_en = 1'b0;
	cisv_fault_type fault_in = '0;
	cisv_event_type event_in = '0;
	int err_total = 0, n_compared = 0, cyc = 0;
	always #50 pclk = ~pclk;
	cisv_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .fault_in(fault_in), .event_in(event_in),
		.module_irq(module_irq));
	cisv_sysirq u_sys (.module_irq(module_irq), .sys_en(sys_en), .cpu_irq(cpu_irq));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	// one apb transfer; holds until pready is sampled
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic pulse(input logic [14:0] e);
		@(posedge pclk);
		event_in <= cisv_event_type'(e);
		@(posedge pclk);
		event_in <= '0;
	endtask : pulse
	// all sources but the error flag at once, then peel them off by priority
	task automatic t_events();
		logic [7:0] clr[4] = '{8'hBF, 8'hBB, 8'hB3, 8'h80};
		logic [31:0] cod[4] = '{32'h0F43, 32'h0F44, 32'h0F05, 32'h0F40};
		apb(1'b1, 12'h004, 32'hEF);
		pulse(15'h7E5F);
		apb(1'b0, 12'h000, 32'h0); check(rd, 32'hCF);
		apb(1'b0, 12'h008, 32'h0); check(rd, 32'h0F42);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h000, {24'h0, clr[i]});
			apb(1'b0, 12'h008, 32'h0); check(rd, cod[i]);
		end
		apb(1'b1, 12'h000, 32'hFF);
		apb(1'b0, 12'h000, 32'h0); check(rd, 32'h80);
		check(module_irq, 1'b1);
		apb(1'b1, 12'h000, 32'h0);
		repeat (2) @(posedge pclk);
		check(module_irq, 1'b0);
	endtask : t_events
	// each fault level alone raises its status and the error flag
	task automatic t_faults();
		logic [4:0] f[5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
		logic [31:0] x[5] = '{32'h2020, 32'h1020, 32'h0820, 32'h0520, 32'h0320};
		for (int i = 0; i < 5; i++) begin
			fault_in <= cisv_fault_type'(f[i]);
			repeat (3) @(posedge pclk);
			apb(1'b0, 12'h000, 32'h0); check(rd, x[i]);
			apb(1'b0, 12'h008, 32'h0); check(rd[6:0], 7'h41);
			apb(1'b1, 12'h000, 32'h0);
		end
		fault_in <= '0;
	endtask : t_faults
	// masked source, gate, unmapped and read-only places
	task automatic t_mask();
		apb(1'b1, 12'h004, 32'h0);
		pulse(15'h2000);
		apb(1'b0, 12'h000, 32'h0); check(rd, 32'h40);
		apb(1'b0, 12'h008, 32'h0); check(rd[6:0], 7'h40);
		check(module_irq, 1'b0);
		apb(1'b1, 12'h004, 32'h40);
		repeat (2) @(posedge pclk);
		check(cpu_irq, 1'b0);
		sys_en <= 1'b1;
		repeat (2) @(posedge pclk);
		check(cpu_irq, 1'b1);
		apb(1'b0, 12'h00C, 32'h0); check(slv, 1'b1);
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b0, 12'h008, 32'h0); check(rd[6:0], 7'h42);
	endtask : t_mask
	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0); check(rd, 32'h0);
		apb(1'b0, 12'h004, 32'h0); check(rd, 32'h0);
		apb(1'b0, 12'h008, 32'h0); check(rd, 32'h40);
		t_events();
		t_faults();
		t_mask();
		print_verdict();
	end
endmodule : cisv_top_tb
`default_nettype wire
